// ### inc/cibd_params.svh
// What this block does
// RULE1: a branch-exchange jumps to the named low or high register, and target bit 0 picks wide (0) or compact (1) state.
// RULE2: software never issues a branch-exchange with the first high-register flag set, since its effect is undefined.
// RULE3: reading the program counter as an operand in compact state gives instruction address plus 4 with bit 0 cleared.
// RULE4: software never runs a branch-exchange on the program counter from a non-word-aligned address.
// RULE5: the pc-relative load fetches one word at the pc plus the 8-bit field shifted left by two, up to 1020 bytes.
// RULE6: the pc-relative base is instruction address plus 4 with bit 1 forced to zero, so it is word aligned.
// RULE7: register-offset transfers address base register plus offset register, both low registers, with no writeback.
// RULE8: register-offset flags load,byte select word store, byte store, word load and byte load for 00, 01, 10, 11.
// RULE9: sign-extend format 00 stores bits 0-15 of the data register as a half-word at base plus offset.
// RULE10: sign-extend format 01 loads an unsigned half-word and clears bits 16-31.
// RULE11: sign-extend format 10 loads a byte and copies bit 7 into bits 8-31.
// RULE12: sign-extend format 11 loads a half-word and copies bit 15 into bits 16-31.
// RULE13: immediate-offset transfers address base plus immediate, flags 00 word store, 01 word load, 10 byte store, 11 byte load.
// RULE14: immediate-offset word transfers scale the 5-bit field by four, byte transfers use it unscaled.
// RULE15: each compact instruction takes the same cycles as its full-width equivalent.
// RULE16: each compact encoding is expanded into full-width control fields that drive one shared execute path.
`ifndef CIBD_PARAMS_SVH
`define CIBD_PARAMS_SVH
// ****************************************
// register offsets
// ****************************************
`define CIBD_OFS_INSTR 8'h00
`define CIBD_OFS_PC 8'h04
`define CIBD_OFS_STAT 8'h08
`define CIBD_OFS_ADDR 8'h0C
`define CIBD_OFS_CTRL 8'h10
`define CIBD_GPR_SEL 2'h1
// ****************************************
// opcode fields
// ****************************************
`define CIBD_BRX_TOP 8'h47
`define CIBD_LIT_TOP 5'h09
`define CIBD_ROFF_TOP 4'h5
`define CIBD_IMM_TOP 3'h3
// ****************************************
// reset values and timing
// ****************************************
`define CIBD_PC_RST 32'h00000000
`define CIBD_COMPACT_RST 1'b1
`define CIBD_PC_AHEAD 32'h00000004
`define CIBD_INSTR_BYTES 32'h00000002
`define CIBD_BRX_FILL 2'h2
`endif

// ### inc/cibd_pkg.sv
package cibd_pkg;
    // transfer width of one memory access
    typedef enum logic [1:0] {CIBD_SZ_BYTE, CIBD_SZ_HALF, CIBD_SZ_WORD} cibd_size_t;
    // execute sequencer
    typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_MEM, ST_WB, ST_FILL} cibd_state_t;
endpackage

// ### hw/cibd_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "cibd_params.svh"
module cibd_decode (
    input wire logic [15:0] instr,
    output logic valid,
    output logic is_brx,
    output logic is_lit,
    output logic is_load,
    output logic is_signed,
    output cibd_pkg::cibd_size_t size,
    output logic off_is_reg,
    output logic [3:0] base_idx,
    output logic [2:0] off_idx,
    output logic [9:0] imm,
    output logic [2:0] rd
);
    import cibd_pkg::*;

    // ****************************************
    // format recognition
    // ****************************************
    wire f_brx = instr[15:8] == `CIBD_BRX_TOP;
    wire f_lit = instr[15:11] == `CIBD_LIT_TOP;
    wire f_roff = instr[15:12] == `CIBD_ROFF_TOP;
    wire f_se = f_roff && instr[9];
    wire f_im = instr[15:13] == `CIBD_IMM_TOP;
    wire [1:0] flg_roff = instr[11:10];
    wire [1:0] flg_im = instr[12:11];

    // expansion into full-width control fields
    assign valid = (f_brx && !instr[7]) || f_lit || f_roff || f_im; // undefined flag refused [RULE2] [RULE16]
    assign is_brx = f_brx; // [RULE1]
    assign is_lit = f_lit; // [RULE5]
    assign is_load = f_lit || (f_roff && !f_se && flg_roff[1]) || (f_se && flg_roff != 2'b00) || (f_im && flg_im[0]); // [RULE8] [RULE13]
    assign is_signed = f_se && flg_roff[1]; // [RULE11] [RULE12]
    assign size = (f_lit || f_brx) ? CIBD_SZ_WORD :
                  f_se ? ((flg_roff == 2'b10) ? CIBD_SZ_BYTE : CIBD_SZ_HALF) : // [RULE9] [RULE10]
                  f_roff ? (flg_roff[0] ? CIBD_SZ_BYTE : CIBD_SZ_WORD) : // [RULE8]
                  (flg_im[1] ? CIBD_SZ_BYTE : CIBD_SZ_WORD); // [RULE13]
    assign off_is_reg = f_roff; // [RULE7]
    assign off_idx = instr[8:6];
    assign base_idx = f_brx ? instr[6:3] : {1'b0, instr[5:3]};
    // word offsets are stored shifted left by two
    assign imm = f_lit ? {instr[7:0], 2'b00} : // [RULE5]
                 (f_im && !flg_im[1]) ? {3'b000, instr[10:6], 2'b00} : // [RULE14]
                 f_im ? {5'b00000, instr[10:6]} : 10'h000;
    assign rd = f_lit ? instr[10:8] : instr[2:0];
endmodule // cibd_decode
`default_nettype wire

// ### hw/cibd_top.sv
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "cibd_params.svh"
module cibd_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic mem_req,
    output logic mem_we,
    output cibd_pkg::cibd_size_t mem_size,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic compact_state
);
    import cibd_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    // one adder shape for every addressing mode
    function automatic logic [31:0] agen(input logic [31:0] base, input logic [31:0] ofs);
        agen = base + ofs;
    endfunction

    // load data extension by width and sign
    function automatic logic [31:0] extend(input logic [31:0] d, input cibd_size_t sz, input logic sgn);
        extend = d;
        if (sz == CIBD_SZ_BYTE)
        begin
            extend = {{24{sgn & d[7]}}, d[7:0]};
        end
        else if (sz == CIBD_SZ_HALF)
        begin
            extend = {{16{sgn & d[15]}}, d[15:0]};
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    cibd_state_t state_q;
    logic [15:0] instr_q;
    logic [31:0] pc_q;
    logic illegal_q;
    logic [7:0] cyc_q;
    logic [7:0] last_cyc_q;
    logic is_load_q;
    logic signed_q;
    cibd_size_t size_q;
    logic [2:0] rd_q;
    logic [1:0] fill_q;
    logic [31:0] ld_data_q;
    logic [31:0] rf_q [0:14];
    logic ap_valid_q;
    logic ap_write_q;
    logic [7:0] ap_addr_q;

    // ****************************************
    // decode of the held instruction
    // ****************************************
    logic dc_valid;
    logic dc_brx;
    logic dc_lit;
    logic dc_load;
    logic dc_signed;
    cibd_size_t dc_size;
    logic dc_off_reg;
    logic [3:0] dc_base;
    logic [2:0] dc_off;
    logic [9:0] dc_imm;
    logic [2:0] dc_rd;

    cibd_decode u_decode (
        .instr(instr_q),
        .valid(dc_valid),
        .is_brx(dc_brx),
        .is_lit(dc_lit),
        .is_load(dc_load),
        .is_signed(dc_signed),
        .size(dc_size),
        .off_is_reg(dc_off_reg),
        .base_idx(dc_base),
        .off_idx(dc_off),
        .imm(dc_imm),
        .rd(dc_rd)
    );

    // ****************************************
    // operands and addresses
    // ****************************************
    // pc reads as address plus 4, bit 0 clear
    wire [31:0] pc_opnd = agen(pc_q, `CIBD_PC_AHEAD) & 32'hFFFFFFFE; // [RULE3]
    wire [31:0] lit_base = pc_opnd & 32'hFFFFFFFC; // bit 1 forced low [RULE6]
    wire [31:0] base_val = (dc_base == 4'hF) ? pc_opnd : rf_q[dc_base]; // [RULE1] [RULE3]
    wire [31:0] off_val = rf_q[{1'b0, dc_off}];
    wire [31:0] rd_val = rf_q[{1'b0, dc_rd}];
    wire [31:0] ofs_val = dc_off_reg ? off_val : {22'h0, dc_imm}; // [RULE7] [RULE14]
    wire [31:0] eff_addr = dc_lit ? agen(lit_base, {22'h0, dc_imm}) : agen(base_val, ofs_val); // [RULE5] [RULE13]
    // store data narrowed to the access width
    wire [31:0] st_data = (dc_size == CIBD_SZ_BYTE) ? {24'h000000, rd_val[7:0]} :
                          (dc_size == CIBD_SZ_HALF) ? {16'h0000, rd_val[15:0]} : rd_val; // [RULE9]
    wire exec_ok = (state_q == ST_EXEC) && ce && dc_valid && compact_state;
    wire is_idle = state_q == ST_IDLE;

    // ****************************************
    // bus decode
    // ****************************************
    // a read waits one cycle so hrdata can come from a flop
    wire ap_take = hsel && htrans[1] && hready;
    wire wr_en = ap_valid_q && ap_write_q && is_idle;
    wire wr_instr = wr_en && (ap_addr_q == `CIBD_OFS_INSTR);
    wire wr_pc = wr_en && (ap_addr_q == `CIBD_OFS_PC);
    wire wr_ctrl = wr_en && (ap_addr_q == `CIBD_OFS_CTRL);
    wire gpr_sel = ap_addr_q[7:6] == `CIBD_GPR_SEL;
    wire [3:0] gidx = ap_addr_q[5:2];
    wire wr_gpr = wr_en && gpr_sel && (gidx != 4'hF);
    wire [31:0] gpr_rd = (gidx == 4'hF) ? pc_q : rf_q[gidx];
    wire [31:0] stat_rd = {16'h0000, last_cyc_q, 5'b00000, illegal_q, compact_state, !is_idle};
    wire [31:0] rd_mux = (ap_addr_q == `CIBD_OFS_INSTR) ? {16'h0000, instr_q} :
                         (ap_addr_q == `CIBD_OFS_PC) ? pc_q :
                         (ap_addr_q == `CIBD_OFS_STAT) ? stat_rd :
                         (ap_addr_q == `CIBD_OFS_ADDR) ? mem_addr :
                         (ap_addr_q == `CIBD_OFS_CTRL) ? {31'h0, compact_state} :
                         gpr_sel ? gpr_rd : 32'h00000000;

    // ahb-lite slave handshake, response always okay
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end
        else if (ce)
        begin
            ap_valid_q <= ap_take;
            if (ap_take)
            begin
                ap_write_q <= hwrite;
                ap_addr_q <= haddr[7:0];
            end
            hreadyout <= !(ap_take && !hwrite);
            if (ap_valid_q && !ap_write_q)
            begin
                hrdata <= rd_mux;
            end
        end
    end

    // ****************************************
    // execute sequencer
    // ****************************************
    // one path serves every expanded encoding, so timing follows the wide form
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_q <= ST_IDLE;
            instr_q <= 16'h0000;
            pc_q <= `CIBD_PC_RST;
            compact_state <= `CIBD_COMPACT_RST;
            illegal_q <= 1'b0;
            cyc_q <= 8'h00;
            last_cyc_q <= 8'h00;
            is_load_q <= 1'b0;
            signed_q <= 1'b0;
            size_q <= CIBD_SZ_WORD;
            rd_q <= 3'h0;
            fill_q <= 2'h0;
            ld_data_q <= 32'h00000000;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_size <= CIBD_SZ_WORD;
            mem_addr <= 32'h00000000;
            mem_wdata <= 32'h00000000;
        end
        else if (ce)
        begin
            cyc_q <= is_idle ? 8'h00 : cyc_q + 8'h01;
            unique case (state_q)
                ST_IDLE:
                begin
                    // a write to the instruction register while busy is dropped
                    if (wr_instr)
                    begin
                        instr_q <= hwdata[15:0];
                        illegal_q <= 1'b0;
                        state_q <= ST_EXEC;
                    end
                    if (wr_pc)
                    begin
                        pc_q <= hwdata;
                    end
                    if (wr_ctrl)
                    begin
                        compact_state <= hwdata[0];
                    end
                end
                ST_EXEC:
                begin
                    if (!dc_valid || !compact_state)
                    begin
                        illegal_q <= 1'b1; // [RULE2]
                        last_cyc_q <= cyc_q + 8'h01;
                        state_q <= ST_IDLE;
                    end
                    else if (dc_brx)
                    begin
                        pc_q <= {base_val[31:1], 1'b0}; // [RULE1]
                        compact_state <= base_val[0]; // [RULE1]
                        fill_q <= `CIBD_BRX_FILL - 2'h1;
                        state_q <= ST_FILL; // [RULE15]
                    end
                    else
                    begin
                        pc_q <= agen(pc_q, `CIBD_INSTR_BYTES);
                        mem_req <= 1'b1; // [RULE16]
                        mem_we <= !dc_load; // [RULE8] [RULE13]
                        mem_size <= dc_size;
                        mem_addr <= eff_addr; // [RULE7]
                        mem_wdata <= st_data; // [RULE9]
                        is_load_q <= dc_load;
                        signed_q <= dc_signed;
                        size_q <= dc_size;
                        rd_q <= dc_rd;
                        state_q <= ST_MEM;
                    end
                end
                ST_MEM:
                begin
                    if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        ld_data_q <= mem_rdata;
                        if (!is_load_q)
                        begin
                            last_cyc_q <= cyc_q + 8'h01;
                        end
                        state_q <= is_load_q ? ST_WB : ST_IDLE; // internal cycle as a wide load [RULE15]
                    end
                end
                ST_WB:
                begin
                    last_cyc_q <= cyc_q + 8'h01;
                    state_q <= ST_IDLE;
                end
                ST_FILL:
                begin
                    fill_q <= fill_q - 2'h1;
                    if (fill_q == 2'h0)
                    begin
                        last_cyc_q <= cyc_q + 8'h01;
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // register file: bus writes only while idle, loads write back
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 15; i++)
            begin
                rf_q[i] <= 32'h00000000;
            end
        end
        else if (ce)
        begin
            if (state_q == ST_WB)
            begin
                rf_q[{1'b0, rd_q}] <= extend(ld_data_q, size_q, signed_q); // [RULE10] [RULE11] [RULE12]
            end
            else if (wr_gpr)
            begin
                rf_q[gidx] <= hwdata;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    wire ex_roff = exec_ok && dc_off_reg && !dc_brx;
    wire ex_im = exec_ok && (instr_q[15:13] == `CIBD_IMM_TOP);

    property p_brx_state;
        @(posedge clk) disable iff (!rst_b)
        (exec_ok && dc_brx) |=> (compact_state == $past(base_val[0])) && (state_q == ST_FILL);
    endproperty
    a_brx_state: assert property (p_brx_state) else $error("branch-exchange state wrong"); // [RULE1]

    property p_pc_opnd;
        @(posedge clk) disable iff (!rst_b)
        (exec_ok && dc_brx && dc_base == 4'hF) |=> pc_q == (($past(pc_q) + 32'h00000004) & 32'hFFFFFFFE);
    endproperty
    a_pc_opnd: assert property (p_pc_opnd) else $error("pc operand value wrong"); // [RULE3]

    property p_lit_addr;
        @(posedge clk) disable iff (!rst_b)
        (exec_ok && dc_lit) |=> mem_req && !mem_we &&
            mem_addr == ((($past(pc_q) + 32'h00000004) & 32'hFFFFFFFC) + {$past(instr_q[7:0]), 2'b00});
    endproperty
    a_lit_addr: assert property (p_lit_addr) else $error("pc-relative address wrong"); // [RULE5] [RULE6]

    property p_roff_addr;
        @(posedge clk) disable iff (!rst_b)
        ex_roff |=> mem_addr == $past(base_val) + $past(off_val);
    endproperty
    a_roff_addr: assert property (p_roff_addr) else $error("register offset address wrong"); // [RULE7]

    property p_roff_op;
        @(posedge clk) disable iff (!rst_b)
        (ex_roff && !instr_q[9]) |=> (mem_we == !$past(instr_q[11])) &&
            (mem_size == ($past(instr_q[10]) ? CIBD_SZ_BYTE : CIBD_SZ_WORD));
    endproperty
    a_roff_op: assert property (p_roff_op) else $error("register offset operation wrong"); // [RULE8]

    property p_half_store;
        @(posedge clk) disable iff (!rst_b)
        (ex_roff && instr_q[11:9] == 3'b001) |=> mem_we && mem_size == CIBD_SZ_HALF &&
            mem_wdata == {16'h0000, $past(rd_val[15:0])};
    endproperty
    a_half_store: assert property (p_half_store) else $error("half-word store wrong"); // [RULE9]

    property p_half_zero;
        @(posedge clk) disable iff (!rst_b)
        (state_q == ST_WB && ce && size_q == CIBD_SZ_HALF && !signed_q) |=> rf_q[{1'b0, rd_q}][31:16] == 16'h0000;
    endproperty
    a_half_zero: assert property (p_half_zero) else $error("unsigned half not cleared"); // [RULE10]

    property p_byte_sext;
        @(posedge clk) disable iff (!rst_b)
        (state_q == ST_WB && ce && size_q == CIBD_SZ_BYTE && signed_q) |=>
            rf_q[{1'b0, rd_q}][31:8] == {24{$past(ld_data_q[7])}};
    endproperty
    a_byte_sext: assert property (p_byte_sext) else $error("signed byte not extended"); // [RULE11]

    property p_half_sext;
        @(posedge clk) disable iff (!rst_b)
        (state_q == ST_WB && ce && size_q == CIBD_SZ_HALF && signed_q) |=>
            rf_q[{1'b0, rd_q}][31:16] == {16{$past(ld_data_q[15])}};
    endproperty
    a_half_sext: assert property (p_half_sext) else $error("signed half not extended"); // [RULE12]

    property p_imm_addr;
        @(posedge clk) disable iff (!rst_b)
        ex_im |=> (mem_we == !$past(instr_q[11])) && (mem_addr - $past(base_val) ==
            ($past(instr_q[12]) ? {27'h0, $past(instr_q[10:6])} : {25'h0, $past(instr_q[10:6]), 2'b00}));
    endproperty
    a_imm_addr: assert property (p_imm_addr) else $error("immediate offset access wrong"); // [RULE13] [RULE14]

    property p_timing;
        @(posedge clk) disable iff (!rst_b)
        (state_q == ST_MEM && ce && mem_ack && is_load_q) ##1 ce |=> state_q == ST_IDLE;
    endproperty
    a_timing: assert property (p_timing) else $error("load cycle count wrong"); // [RULE15] [RULE16]
endmodule // cibd_top
`default_nettype wire

// ### verif/tb_cibd_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "cibd_params.svh"
module tb_cibd_top;
    import cibd_pkg::*;
    // ********
    // signals and design
    // ********
    localparam logic [31:0] A_INSTR = {24'h000000, `CIBD_OFS_INSTR};
    localparam logic [31:0] A_PC = {24'h000000, `CIBD_OFS_PC};
    localparam logic [31:0] A_STAT = {24'h000000, `CIBD_OFS_STAT};
    localparam logic [31:0] A_CTRL = {24'h000000, `CIBD_OFS_CTRL};
    localparam logic [31:0] GPR = 32'h00000040;
    localparam logic [31:0] SX [4] = '{32'h00005A81, 32'h00008A96, 32'hFFFFFF96, 32'hFFFF8A96};
    logic clk, rst_b, ce, hsel, hwrite, hreadyout, hresp, mem_req, mem_we, mem_ack, compact_state, seen_we;
    logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, seen_addr, seen_wdata, rdv, got;
    logic [1:0] htrans;
    logic [2:0] hsize;
    cibd_size_t mem_size, seen_size;
    int errors, n_tests, ack_dly, wcnt;
    cibd_top dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .compact_state(compact_state));
    // clock, 50 ns period
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // memory responder; idle data is inverted so a stale read cannot pass
    always @(posedge clk)
    begin
        if (mem_req && mem_ack)
        begin
            seen_addr <= mem_addr;
            seen_we <= mem_we;
            seen_size <= mem_size;
            seen_wdata <= mem_wdata;
        end
        mem_ack <= mem_req && !mem_ack && wcnt >= ack_dly;
        mem_rdata <= (mem_req && !mem_ack && wcnt >= ack_dly) ? rdv : ~rdv;
        wcnt <= (mem_req && !mem_ack) ? wcnt + 1 : 0;
    end
    // ********
    // bus and compare tasks
    // ********
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // bounded wait for an edge with hready high
    task wait_rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 50);
    endtask
    // one single word transfer; read data lands in got
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        got = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task setr(input logic [3:0] n, input logic [31:0] v);
        ahb(1'b1, GPR + {26'h0, n, 2'h0}, v);
    endtask
    task chk_ld(input logic [3:0] n, input logic [31:0] e);
        ahb(1'b0, GPR + {26'h0, n, 2'h0}, 32'h0);
        chk(got, e);
    endtask
    task chk_acc(input logic we, input cibd_size_t sz, input logic [31:0] ad);
        chk({31'h0, seen_we}, {31'h0, we});
        chk({30'h0, seen_size}, {30'h0, sz});
        chk(seen_addr, ad);
    endtask
    // start one instruction, then poll busy; status lands in got
    task exec(input logic [15:0] ins);
        int k;
        ahb(1'b1, A_INSTR, {16'h0, ins});
        k = 0;
        do
        begin
            ahb(1'b0, A_STAT, 32'h0);
            k++;
        end
        while (got[0] !== 1'b0 && k < 20);
        chk({31'h0, got[0]}, 32'h0);
    endtask
    // ********
    // scenarios
    // ********
    task s_regs;
        ahb(1'b0, A_STAT, 32'h0);
        chk(got, 32'h00000002);
        ahb(1'b0, A_CTRL, 32'h0);
        chk(got, 32'h00000001);
        ahb(1'b1, 32'h00000020, 32'hFFFFFFFF);
        ahb(1'b0, 32'h00000020, 32'h0);
        chk(got, 32'h00000000);
    endtask
    task s_regoff;
        setr(4'h1, 32'h00001000);
        setr(4'h2, 32'h00000024);
        setr(4'h3, 32'hCAFE5A81);
        for (int i = 0; i < 4; i++)
        begin
            setr(4'h4, 32'h0);
            exec({4'h5, i[1:0], 1'b0, 3'h2, 3'h1, i[1] ? 3'h4 : 3'h3});
            chk({24'h0, got[15:8]}, i[1] ? 32'h4 : 32'h3);
            chk_acc(!i[1], i[0] ? CIBD_SZ_BYTE : CIBD_SZ_WORD, 32'h00001024);
            if (i[1])
                chk_ld(4'h4, i[0] ? 32'h00000096 : rdv);
            else
                chk(seen_wdata, i[0] ? 32'h00000081 : 32'hCAFE5A81);
        end
        chk_ld(4'h1, 32'h00001000);
    endtask
    task s_sext;
        for (int i = 0; i < 4; i++)
        begin
            exec({4'h5, i[1:0], 1'b1, 3'h2, 3'h1, i == 0 ? 3'h3 : 3'h4});
            chk_acc(i == 0, i == 2 ? CIBD_SZ_BYTE : CIBD_SZ_HALF, 32'h00001024);
            if (i == 0)
                chk(seen_wdata, SX[0]);
            else
                chk_ld(4'h4, SX[i]);
        end
    endtask
    // slow memory: two extra wait cycles on every access
    task s_imm;
        ack_dly = 2;
        for (int i = 0; i < 4; i++)
        begin
            exec({3'h3, i[1:0], 5'h1D, 3'h1, i[0] ? 3'h4 : 3'h3});
            chk({24'h0, got[15:8]}, i[0] ? 32'h6 : 32'h5);
            chk_acc(!i[0], i[1] ? CIBD_SZ_BYTE : CIBD_SZ_WORD, i[1] ? 32'h0000101D : 32'h00001074);
            if (i[0])
                chk_ld(4'h4, i[1] ? 32'h00000096 : rdv);
            else
                chk(seen_wdata, i[1] ? 32'h00000081 : 32'hCAFE5A81);
        end
        ack_dly = 0;
    endtask
    // base taken from an address with bit 1 set, then the largest offset
    task s_lit;
        ahb(1'b1, A_PC, 32'h00000102);
        exec({5'h09, 3'h6, 8'hD3});
        chk_acc(1'b0, CIBD_SZ_WORD, 32'h00000450);
        chk_ld(4'h6, rdv);
        ahb(1'b0, {24'h000000, `CIBD_OFS_ADDR}, 32'h0);
        chk(got, 32'h00000450);
        ahb(1'b1, A_PC, 32'h00000100);
        exec({5'h09, 3'h6, 8'hFF});
        chk(seen_addr, 32'h00000500);
    endtask
    task s_brx;
        setr(4'h5, 32'h00000201);
        setr(4'h9, 32'h00000300);
        ahb(1'b1, A_PC, 32'h00000100);
        exec(16'h4728);
        chk({24'h0, got[15:8]}, 32'h3);
        ahb(1'b0, A_PC, 32'h0);
        chk(got, 32'h00000200);
        chk({31'h0, compact_state}, 32'h1);
        exec(16'h4748);
        ahb(1'b0, A_PC, 32'h0);
        chk(got, 32'h00000300);
        chk({31'h0, compact_state}, 32'h0);
        // word-aligned source, so the branch on the counter is defined
        ahb(1'b1, A_CTRL, 32'h1);
        ahb(1'b1, A_PC, 32'h00000400);
        exec(16'h4778);
        ahb(1'b0, A_PC, 32'h0);
        chk(got, 32'h00000404);
        chk({31'h0, compact_state}, 32'h0);
        // first high flag set: refused, counter unchanged
        ahb(1'b1, A_CTRL, 32'h1);
        ahb(1'b1, A_PC, 32'h00000500);
        exec(16'h47A8);
        chk({31'h0, got[2]}, 32'h1);
        ahb(1'b0, A_PC, 32'h0);
        chk(got, 32'h00000500);
    endtask
    // ********
    // run control
    // ********
    task wrap_up;
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // the whole run needs a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        wrap_up;
    end
    initial
    begin
        {rst_b, hsel, hwrite, mem_ack, wcnt, ack_dly, errors, n_tests} = '0;
        {haddr, hwdata, mem_rdata, htrans} = '0;
        ce = 1'b1;
        hsize = 3'h2;
        rdv = 32'h12348A96;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        s_regs;
        s_regoff;
        s_sext;
        s_imm;
        s_lit;
        s_brx;
        wrap_up;
    end
endmodule // tb_cibd_top
`default_nettype wire
